// ===== hsw_host.sv
// Host model that issues single-byte commands to the supervisor.
`timescale 1ns/1ps
module hsw_host (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic send,
    input wire logic stale,
    input wire logic [1:0] sel,
    input wire logic [6:0] payload,
    output logic cfg_wr,
    output logic [1:0] cfg_sel,
    output logic [7:0] cfg_data
);
    logic toggle_q;
    logic toggle_d;

    // A stale command repeats the last toggle value, so the watchdog starves.
    assign toggle_d = stale ? toggle_q : ~toggle_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            toggle_q <= 1'b0;
            cfg_wr <= 1'b0;
            cfg_sel <= 2'h3;
            cfg_data <= 8'h00;
        end
        else
        begin
            cfg_wr <= send;
            if (send)
            begin
                cfg_sel <= sel;
                cfg_data <= {toggle_d, 1'b0, payload[5:0]};
                toggle_q <= toggle_d;
            end
            else
            begin
                // Scramble the idle byte so nothing relies on a held value.
                cfg_data <= ~cfg_data;
            end
        end
    end
endmodule

// ===== hsw_pkg.sv
// Shared constants and types for the high-side switch mode and fault supervisor.
package hsw_pkg;
    typedef enum logic [1:0] {
        HSW_SLEEP    = 2'b00,
        HSW_NORMAL   = 2'b01,
        HSW_FAULT    = 2'b10,
        HSW_FAILSAFE = 2'b11
    } hsw_mode_e;

    // Pre-decoded fail-safe resistor selection.
    localparam logic [1:0] FSR_DISABLED = 2'h0;
    localparam logic [1:0] FSR_BOTH_OFF = 2'h1;
    localparam logic [1:0] FSR_OUT0_ON = 2'h2;
    localparam logic [1:0] FSR_BOTH_ON = 2'h3;

    // Configuration write selectors.
    localparam logic [1:0] SEL_OUTPUT = 2'h0;
    localparam logic [1:0] SEL_OVERCURRENT = 2'h1;
    localparam logic [1:0] SEL_CONFIG = 2'h2;

    // Field positions inside a command byte.
    localparam int TOGGLE_POS = 7;
    localparam int OC_LOW_LSB = 0;
    localparam int OC_HIGH_POS = 3;
    localparam int OC_TIME_LSB = 4;
    localparam int WD_PERIOD_LSB = 0;
    localparam int OV_OFF_POS = 2;
    localparam int UV_OFF_POS = 3;

    // Fault register bit positions.
    localparam int FLT_OVERTEMP = 0;
    localparam int FLT_OVERVOLT = 1;
    localparam int FLT_UNDERVOLT = 2;
    localparam int FLT_OVERCURRENT = 3;
    localparam int FLT_OPEN_LOAD = 4;

    // Reset values.
    localparam logic [2:0] OC_LOW_RESET = 3'h0;
    localparam logic OC_HIGH_RESET = 1'b0;
    localparam logic [1:0] OC_TIME_RESET = 2'h0;
    localparam logic [1:0] WD_PERIOD_RESET = 2'h0;
    localparam logic [7:0] FAULT_RESET = 8'h00;

    // Watchdog timing: shortest period, doubled per period-field step.
    localparam int CLK_KHZ = 50000;
    localparam int WD_UNIT_MS = 10;
    localparam int WD_UNIT_CYC = WD_UNIT_MS * CLK_KHZ;
endpackage

// ===== hsw_supervisor.sv
// Mode, watchdog, fail-safe and fault supervisor for a dual high-side switch.
// Function
// RULE1: Sleep is the state after power-up.
// RULE2: Wake and reset pins low mean sleep.
// RULE3: Sleep treats all configuration as zero; the overcurrent settings are not masked in sleep.
// RULE4: Normal needs good battery, reset high, no fault.
// RULE5: Rising wake or reset arms the watchdog.
// RULE6: Host toggles bit seven before timeout.
// RULE7: Watchdog expiry latches fail-safe mode.
// RULE8: Fail-safe outputs follow resistor selection.
// RULE9: Fail-safe entry restores overcurrent defaults.
// RULE10: Expired bit reads one during fail-safe.
// RULE11: Both pins low or grounded pin exits.
// RULE12: Grounded config pin disables watchdog, fail-safe.
// RULE13: Logic supply loss resets registers only.
// RULE14: Any fault drives fault flag low.
// RULE15: Flag self-releases except overcurrent, latched undervoltage.
// RULE16: Fault register clears as it is read.
// RULE17: Overtemperature switches on output off, repeats.
// RULE18: Overtemperature flag clears on read only.
// RULE19: Overvoltage holds output off, can be disabled.
// RULE20: Undervoltage: output off, flag low, flag set.
// RULE21: Recovery with command off releases flag.
// RULE22: Recovery with command on stays latched.
// RULE23: Undervoltage disable hides fault above 2.5 V.
// RULE24: Resistor selection arrives as two-bit code.
`timescale 1ns/1ps
module hsw_supervisor
    import hsw_pkg::*;
#(
    parameter int WD_UNIT_CYCLES = hsw_pkg::WD_UNIT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wake_pin,
    input wire logic reset_pin,
    input wire logic vdd_ok,
    input wire logic failsafe_config_pin,
    input wire logic [1:0] failsafe_resistor,
    input wire logic [1:0] direct_inputs,
    input wire logic batt_normal,
    input wire logic batt_under,
    input wire logic batt_above_min,
    input wire logic batt_over,
    input wire logic [1:0] overtemp,
    input wire logic [1:0] open_load,
    input wire logic [1:0] overcurrent,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_sel,
    input wire logic [7:0] cfg_data,
    input wire logic fault_read,
    input wire logic fault_flag_pin_in,
    output logic fault_flag_pin_out,
    output logic fault_flag_pin_oe,
    output logic output_switch_0,
    output logic output_switch_1,
    output logic [7:0] fault_reg,
    output logic watchdog_expired_bit,
    output hsw_pkg::hsw_mode_e mode,
    output logic [2:0] oc_low_level,
    output logic oc_high_level,
    output logic [1:0] oc_low_time,
    output logic fault_line_low
);
    import hsw_pkg::*;

    logic wake_s;
    logic reset_s;
    logic vdd_s;
    logic fsi_s;
    logic [1:0] fsr_s;
    logic [1:0] din_s;
    logic bnorm_s;
    logic bunder_s;
    logic bmin_s;
    logic bover_s;
    logic [1:0] ot_s;
    logic [1:0] ol_s;
    logic [1:0] oc_s;
    logic flag_s;

    hsw_sync #(.W(19)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin({wake_pin, reset_pin, vdd_ok, failsafe_config_pin,
              failsafe_resistor, direct_inputs, batt_normal, batt_under,
              batt_above_min, batt_over, overtemp, open_load, overcurrent,
              fault_flag_pin_in}),
        .sync({wake_s, reset_s, vdd_s, fsi_s, fsr_s, din_s, bnorm_s,
               bunder_s, bmin_s, bover_s, ot_s, ol_s, oc_s, flag_s})
    );

    function automatic logic [31:0] wd_limit(input logic [1:0] period);
        wd_limit = 32'(WD_UNIT_CYCLES) << period;
    endfunction

    logic wake_q;
    logic reset_q;
    logic [1:0] out_cmd_q;
    logic [2:0] oc_low_q;
    logic oc_high_q;
    logic [1:0] oc_time_q;
    logic [1:0] wd_period_q;
    logic ov_off_q;
    logic uv_off_q;
    logic toggle_q;
    logic wd_armed_q;
    logic [31:0] wd_cnt_q;
    logic failsafe_q;
    logic [1:0] uv_latch_q;
    logic [1:0] oc_latch_q;
    logic [1:0] want_q;
    logic [1:0] drive_q;
    logic [7:0] fault_q;
    logic fault_pin_q;
    hsw_mode_e mode_q;

    // Both pins low is sleep, and sleep masks the output command, OV/UV disables and watchdog period, but not the overcurrent settings.
    wire sleep = !wake_s && !reset_s; // RULE2
    wire fsi_grounded = !fsi_s;
    wire arm_edge = (wake_s && !wake_q) || (reset_s && !reset_q); // RULE5
    wire fs_exit = (sleep && (wake_q || reset_q)) || fsi_grounded; // RULE11
    wire fs_allowed = !fsi_grounded && fsr_s != FSR_DISABLED; // RULE12 RULE24
    wire [1:0] cmd_eff = sleep ? 2'h0 : out_cmd_q; // RULE3
    wire ov_off_eff = !sleep && ov_off_q; // RULE3
    wire uv_off_eff = !sleep && uv_off_q; // RULE3
    wire [1:0] wd_period_eff = sleep ? 2'h0 : wd_period_q; // RULE3
    wire toggle_seen = cfg_wr && cfg_data[TOGGLE_POS] != toggle_q; // RULE6
    wire wd_expire = wd_armed_q && fs_allowed && !failsafe_q &&
                     wd_cnt_q >= wd_limit(wd_period_eff) - 32'h1; // RULE7
    wire fs_enter = wd_expire && !toggle_seen;

    // Fail-safe replaces every other source of the on command.
    wire [1:0] fs_cmd = (fsr_s == FSR_BOTH_ON) ? 2'h3 :
                        (fsr_s == FSR_OUT0_ON) ? 2'h1 : 2'h0; // RULE8
    wire [1:0] want = failsafe_q ? fs_cmd : (din_s | cmd_eff); // RULE8 RULE13

    // Protection terms.
    wire ov_act = bover_s && !ov_off_eff; // RULE19
    wire uv_act = bunder_s && !uv_off_eff; // RULE20 RULE23
    wire below_min = uv_off_eff && !bmin_s; // RULE23
    wire [1:0] ot_act = ot_s & want; // RULE17
    wire [1:0] uv_set = {2{uv_act}} & want; // RULE22
    wire [1:0] want_fall = want_q & ~want;
    wire [1:0] drive = want & ~ot_act & ~uv_latch_q & ~oc_latch_q &
                       ~{2{ov_act || uv_act || below_min || sleep}};

    // Open load counts only while the output is off.
    wire [1:0] ol_act = ol_s & ~drive_q;
    wire any_fault = |ot_act || |ol_act || |oc_latch_q || |oc_s ||
                     ov_act || uv_act || |uv_latch_q; // RULE14 RULE15

    wire [7:0] fault_set = {3'h0, |ol_act, |oc_s, uv_act, ov_act,
                            |ot_act}; // RULE18 RULE19 RULE20
    wire [7:0] fault_d = fault_set |
                         (fault_read ? 8'h00 : fault_q); // RULE16 RULE21

    wire wr_out = cfg_wr && cfg_sel == SEL_OUTPUT;
    wire wr_oc = cfg_wr && cfg_sel == SEL_OVERCURRENT;
    wire wr_cfg = cfg_wr && cfg_sel == SEL_CONFIG;

    hsw_mode_e mode_d;
    assign mode_d = sleep ? HSW_SLEEP :
                    failsafe_q ? HSW_FAILSAFE :
                    (bnorm_s && reset_s && !any_fault) ? HSW_NORMAL :
                    HSW_FAULT; // RULE4

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wake_q <= 1'b0;
            reset_q <= 1'b0;
            mode_q <= HSW_SLEEP; // RULE1
            want_q <= 2'h0;
            drive_q <= 2'h0;
            fault_pin_q <= 1'b0;
        end
        else
        begin
            wake_q <= wake_s;
            reset_q <= reset_s;
            mode_q <= mode_d;
            want_q <= want;
            drive_q <= drive;
            fault_pin_q <= any_fault;
        end
    end

    // Registers lose their contents with the logic supply; the watchdog
    // and protections below keep running on the defaults.
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !vdd_s) // RULE13
        begin
            out_cmd_q <= 2'h0;
            wd_period_q <= WD_PERIOD_RESET;
            ov_off_q <= 1'b0;
            uv_off_q <= 1'b0;
            toggle_q <= 1'b0;
        end
        else
        begin
            if (wr_out)
                out_cmd_q <= cfg_data[1:0];
            if (wr_cfg)
            begin
                wd_period_q <= cfg_data[WD_PERIOD_LSB +: 2];
                ov_off_q <= cfg_data[OV_OFF_POS];
                uv_off_q <= cfg_data[UV_OFF_POS];
            end
            if (cfg_wr)
                toggle_q <= cfg_data[TOGGLE_POS];
        end
    end

    // Overcurrent settings fall back to defaults on fail-safe entry.
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !vdd_s || fs_enter) // RULE9 RULE13
        begin
            oc_low_q <= OC_LOW_RESET;
            oc_high_q <= OC_HIGH_RESET;
            oc_time_q <= OC_TIME_RESET;
        end
        else if (wr_oc)
        begin
            oc_low_q <= cfg_data[OC_LOW_LSB +: 3];
            oc_high_q <= cfg_data[OC_HIGH_POS];
            oc_time_q <= cfg_data[OC_TIME_LSB +: 2];
        end
    end

    // Watchdog: armed by a rising wake or reset pin, restarted by a toggle.
    always_ff @(posedge mclk)
    begin
        if (!rst_n || sleep || !fs_allowed) // RULE12
        begin
            wd_armed_q <= 1'b0;
            wd_cnt_q <= 32'h0;
        end
        else
        begin
            if (arm_edge)
                wd_armed_q <= 1'b1; // RULE5
            if (toggle_seen || !wd_armed_q || failsafe_q)
                wd_cnt_q <= 32'h0; // RULE6
            else
                wd_cnt_q <= wd_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n || fs_exit || !fs_allowed) // RULE11 RULE12
            failsafe_q <= 1'b0;
        else if (fs_enter)
            failsafe_q <= 1'b1; // RULE7
    end

    // Latches clear only when the on command drops, so a host must cycle
    // the output off and on; a fault sets a latch only while that output is commanded on.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            uv_latch_q <= 2'h0;
            oc_latch_q <= 2'h0;
        end
        else
        begin
            uv_latch_q <= uv_set | (uv_latch_q & ~want_fall); // RULE22
            oc_latch_q <= (oc_s & want) | (oc_latch_q & ~want_fall); // RULE15
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            fault_q <= FAULT_RESET;
        else
            fault_q <= fault_d; // RULE16 RULE18
    end

    assign output_switch_0 = drive_q[0];
    assign output_switch_1 = drive_q[1];
    assign fault_flag_pin_out = 1'b0;
    assign fault_flag_pin_oe = !fault_pin_q; // RULE14
    assign fault_reg = fault_q;
    assign watchdog_expired_bit = failsafe_q; // RULE10
    assign mode = mode_q;
    assign oc_low_level = oc_low_q;
    assign oc_high_level = oc_high_q;
    assign oc_low_time = oc_time_q;
    assign fault_line_low = !flag_s;

    sleep_off_a: assert property (@(posedge mclk) // RULE2
        disable iff (!rst_n)
        sleep |=> drive_q == 2'h0 && mode_q == HSW_SLEEP)
        else $error("outputs on in sleep");

    expire_fs_a: assert property (@(posedge mclk) // RULE7
        disable iff (!rst_n)
        fs_enter && !fs_exit |=> failsafe_q && watchdog_expired_bit)
        else $error("watchdog expiry missed fail-safe");

    fs_drive_a: assert property (@(posedge mclk) // RULE8
        disable iff (!rst_n)
        failsafe_q && fsr_s == FSR_BOTH_OFF |=> drive_q == 2'h0)
        else $error("fail-safe both-off violated");

    oc_default_a: assert property (@(posedge mclk) // RULE9
        disable iff (!rst_n)
        fs_enter |=> oc_low_q == OC_LOW_RESET && oc_time_q == OC_TIME_RESET)
        else $error("overcurrent settings kept on fail-safe");

    gnd_disable_a: assert property (@(posedge mclk) // RULE12
        disable iff (!rst_n)
        fsi_grounded |=> !failsafe_q && wd_cnt_q == 32'h0)
        else $error("watchdog active with grounded pin");

    flag_low_a: assert property (@(posedge mclk) // RULE14 RULE19
        disable iff (!rst_n)
        $rose(ov_act) |=> !fault_flag_pin_oe ##0 fault_q[FLT_OVERVOLT])
        else $error("overvoltage not flagged");

    read_clear_a: assert property (@(posedge mclk) // RULE16
        disable iff (!rst_n)
        fault_read && fault_set == 8'h00 |=> fault_q == 8'h00)
        else $error("fault register not cleared by read");

    set_wins_a: assert property (@(posedge mclk) // RULE18
        disable iff (!rst_n)
        fault_read && ot_act != 2'h0 |=> fault_q[FLT_OVERTEMP])
        else $error("overtemperature lost on read");

    uv_latch_a: assert property (@(posedge mclk) // RULE22
        disable iff (!rst_n)
        uv_set[0] ##1 !uv_act && want[0] |-> drive[0] == 1'b0)
        else $error("undervoltage latch released early");

    uv_hide_a: assert property (@(posedge mclk) // RULE23
        disable iff (!rst_n)
        uv_off_eff && bmin_s && !ov_act && !fault_q[FLT_UNDERVOLT]
        |=> !fault_q[FLT_UNDERVOLT])
        else $error("undervoltage reported while disabled");

    uv_flag_a: assert property (@(posedge mclk) // RULE20
        disable iff (!rst_n)
        uv_act |=> fault_q[FLT_UNDERVOLT] && !fault_flag_pin_oe &&
        drive_q == 2'h0)
        else $error("undervoltage did not shut down and flag");

    ot_off_a: assert property (@(posedge mclk) // RULE17
        disable iff (!rst_n)
        ot_act[0] |=> !drive_q[0] && fault_q[FLT_OVERTEMP])
        else $error("overtemperature left output on");
endmodule

// ===== hsw_sync.sv
// Two-stage synchroniser bank for pins entering the mclk domain.
`timescale 1ns/1ps
module hsw_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    assign sync = sync_q;
endmodule

// ===== tb.sv
// Self-checking bench for the high-side switch supervisor.
`timescale 1ns/1ps
module tb;
    import hsw_pkg::*;
    typedef struct packed {logic [2:0] sig; logic [7:0] val;} hsw_note_s;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wake_pin = 1'b0;
    logic reset_pin = 1'b0;
    logic failsafe_config_pin = 1'b0;
    logic [1:0] failsafe_resistor = FSR_OUT0_ON;
    logic [1:0] direct_inputs = 2'h0;
    logic batt_under = 1'b0;
    logic batt_over = 1'b0;
    logic [1:0] overtemp = 2'h0;
    logic [1:0] overcurrent = 2'h0;
    logic vdd_ok = 1'b1;
    logic batt_above_min = 1'b1;
    logic fault_line_low;
    logic fault_read = 1'b0;
    logic send = 1'b0;
    logic stale = 1'b0;
    logic [1:0] sel = 2'h3;
    logic [6:0] payload = 7'h00;
    logic [31:0] rng = 32'h000081ae;
    logic cfg_wr, fault_flag_pin_out, fault_flag_pin_oe, fault_level;
    logic [1:0] cfg_sel, oc_low_time;
    logic [7:0] cfg_data, fault_reg;
    logic output_switch_0, output_switch_1, watchdog_expired_bit;
    logic [2:0] oc_low_level;
    logic oc_high_level;
    hsw_mode_e mode;
    hsw_note_s notes[$];
    int fail_count = 0;
    int n_tests = 0;

    // Open-drain flag with a pull-up: released means high.
    assign fault_level = fault_flag_pin_oe ? 1'b1 : fault_flag_pin_out;

    hsw_host host (.mclk(mclk), .rst_n(rst_n), .send(send), .stale(stale),
        .sel(sel), .payload(payload), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
        .cfg_data(cfg_data));

    hsw_supervisor #(.WD_UNIT_CYCLES(16)) dut (.mclk(mclk), .rst_n(rst_n),
        .wake_pin(wake_pin), .reset_pin(reset_pin), .vdd_ok(vdd_ok),
        .failsafe_config_pin(failsafe_config_pin),
        .failsafe_resistor(failsafe_resistor),
        .direct_inputs(direct_inputs), .batt_normal(!batt_under),
        .batt_under(batt_under), .batt_above_min(batt_above_min),
        .batt_over(batt_over), .overtemp(overtemp), .open_load(2'h0),
        .overcurrent(overcurrent), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
        .cfg_data(cfg_data), .fault_read(fault_read),
        .fault_flag_pin_in(fault_level),
        .fault_flag_pin_out(fault_flag_pin_out),
        .fault_flag_pin_oe(fault_flag_pin_oe),
        .output_switch_0(output_switch_0),
        .output_switch_1(output_switch_1), .fault_reg(fault_reg),
        .watchdog_expired_bit(watchdog_expired_bit), .mode(mode),
        .oc_low_level(oc_low_level), .oc_high_level(oc_high_level),
        .oc_low_time(oc_low_time), .fault_line_low(fault_line_low));

    initial
    begin
        forever #10 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    function automatic logic [7:0] actual(input logic [2:0] s);
        case (s)
            3'h0: return {6'h00, mode};
            3'h1: return {6'h00, output_switch_1, output_switch_0};
            3'h2: return fault_reg;
            3'h3: return {7'h00, fault_flag_pin_oe};
            3'h4: return {7'h00, watchdog_expired_bit};
            3'h6: return {7'h00, fault_line_low};
            default: return {2'h0, oc_low_time, oc_high_level, oc_low_level};
        endcase
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic expect_val(input logic [2:0] s, input logic [7:0] v);
        notes.push_back({s, v});
    endtask

    task automatic compare(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want)
        begin
            fail_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    // Two edges per command keep send from being driven twice in one step.
    task automatic cmd(input logic [1:0] s, input logic [6:0] p);
        send <= 1'b1;
        sel <= s;
        payload <= p;
        step(1);
        send <= 1'b0;
        step(1);
    endtask

    task automatic pulse_read();
        fault_read <= 1'b1;
        step(1);
        fault_read <= 1'b0;
        step(1);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Results are compared mid-cycle, once every output has settled.
    always @(negedge mclk)
    begin
        hsw_note_s note;
        while (notes.size() > 0)
        begin
            note = notes.pop_front();
            compare(actual(note.sig), note.val);
        end
    end

    initial
    begin
        #(20 * 5000);
        fail_count++;
        end_of_test();
    end

    initial
    begin
        int n;
        step(5);
        rst_n <= 1'b1;
        step(4);
        expect_val(3'h0, {6'h00, HSW_SLEEP});
        expect_val(3'h1, 8'h00);
        expect_val(3'h5, 8'h00);
        $display("test power_up done");
        wake_pin <= 1'b1;
        reset_pin <= 1'b1;
        step(4);
        expect_val(3'h0, {6'h00, HSW_NORMAL});
        cmd(SEL_OUTPUT, 7'h03);
        step(110);
        expect_val(3'h1, 8'h03);
        expect_val(3'h4, 8'h00);
        $display("test normal done");
        for (int i = 0; i < 2; i++)
        begin
            if (i == 0)
                overtemp <= 2'h1;
            else
                batt_over <= 1'b1;
            step(4);
            expect_val(3'h1, i == 0 ? 8'h02 : 8'h00);
            expect_val(3'h2, i == 0 ? 8'h01 : 8'h02);
            expect_val(3'h3, 8'h00);
            pulse_read();
            expect_val(3'h2, i == 0 ? 8'h01 : 8'h02);
            overtemp <= 2'h0;
            batt_over <= 1'b0;
            step(4);
            expect_val(3'h3, 8'h01);
            expect_val(3'h1, 8'h03);
            pulse_read();
            expect_val(3'h2, 8'h00);
        end
        batt_under <= 1'b1;
        step(4);
        expect_val(3'h1, 8'h00);
        expect_val(3'h3, 8'h00);
        expect_val(3'h2, 8'h04);
        batt_under <= 1'b0;
        step(4);
        expect_val(3'h3, 8'h00);
        expect_val(3'h1, 8'h00);
        expect_val(3'h6, 8'h01);
        cmd(SEL_OUTPUT, 7'h00);
        step(4);
        expect_val(3'h3, 8'h01);
        expect_val(3'h2, 8'h04);
        expect_val(3'h6, 8'h00);
        cmd(SEL_OUTPUT, 7'h03);
        pulse_read();
        step(2);
        expect_val(3'h1, 8'h03);
        expect_val(3'h2, 8'h00);
        overcurrent <= 2'h1;
        step(4);
        expect_val(3'h2, 8'h08);
        overcurrent <= 2'h0;
        step(4);
        expect_val(3'h1, 8'h02);
        expect_val(3'h3, 8'h00);
        cmd(SEL_OUTPUT, 7'h00);
        cmd(SEL_OUTPUT, 7'h03);
        pulse_read();
        expect_val(3'h1, 8'h03);
        expect_val(3'h3, 8'h01);
        expect_val(3'h2, 8'h00);
        cmd(SEL_CONFIG, 7'h08);
        batt_under <= 1'b1;
        step(4);
        expect_val(3'h1, 8'h03);
        expect_val(3'h3, 8'h01);
        expect_val(3'h2, 8'h00);
        batt_above_min <= 1'b0;
        step(4);
        expect_val(3'h1, 8'h00);
        expect_val(3'h3, 8'h01);
        batt_above_min <= 1'b1;
        batt_under <= 1'b0;
        cmd(SEL_CONFIG, 7'h00);
        vdd_ok <= 1'b0;
        direct_inputs <= 2'h1;
        step(4);
        expect_val(3'h1, 8'h01);
        vdd_ok <= 1'b1;
        direct_inputs <= 2'h0;
        step(4);
        expect_val(3'h1, 8'h00);
        $display("test faults done");
        for (int k = 1; k < 4; k++)
        begin
            wake_pin <= 1'b0;
            reset_pin <= 1'b0;
            step(4);
            expect_val(3'h0, {6'h00, HSW_SLEEP});
            failsafe_config_pin <= 1'b1;
            failsafe_resistor <= 2'(k);
            wake_pin <= 1'b1;
            reset_pin <= 1'b1;
            step(4);
            rng = xs(rng);
            cmd(SEL_OVERCURRENT, {1'b0, rng[5:0]});
            step(1);
            expect_val(3'h5, {2'h0, rng[5:0]});
            repeat (6)
            begin
                cmd(2'h3, 7'h00);
                step(8);
            end
            expect_val(3'h0, {6'h00, HSW_NORMAL});
            stale <= 1'b1;
            cmd(2'h3, 7'h00);
            stale <= 1'b0;
            direct_inputs <= rng[9:8];
            n = 0;
            // The mode is polled between edges, away from its own update.
            while (mode !== HSW_FAILSAFE && n < 300)
            begin
                @(negedge mclk);
                n++;
            end
            step(2);
            expect_val(3'h0, {6'h00, HSW_FAILSAFE});
            expect_val(3'h4, 8'h01);
            expect_val(3'h1, {6'h00, k == 3, k != 1});
            expect_val(3'h5, 8'h00);
            if (k == 3)
                failsafe_config_pin <= 1'b0;
            else
            begin
                wake_pin <= 1'b0;
                reset_pin <= 1'b0;
            end
            step(4);
            expect_val(3'h4, 8'h00);
            direct_inputs <= 2'h0;
        end
        $display("test watchdog done");
        step(2);
        end_of_test();
    end
endmodule
